// File: rtl/spare_lane_map.vh
/*
  Address map, field positions, reset values and widths of the spare-lane
  enable block. Definitions only; included by bare name from rtl/.
*/
`ifndef SPARE_LANE_MAP_VH
`define SPARE_LANE_MAP_VH

`define REG_ADDR_W              12
`define REG_DATA_W              8
`define LANE_COUNT              8

`define LINK_A_SPARE_LANE_ADDR  12'h20a
`define LINK_B_SPARE_LANE_ADDR  12'h20b
`define LINK_A_SER_STATUS_ADDR  12'h2b0
`define LINK_B_SER_STATUS_ADDR  12'h2b1
`define LINK_A_CLK_STATUS_ADDR  12'h2b2
`define LINK_B_CLK_STATUS_ADDR  12'h2b3
`define PENDING_STATUS_ADDR     12'h2b4

`define SPARE_LANE_FIELD_MSB    7
`define SPARE_LANE_FIELD_LSB    1
`define SPARE_SER_BIT           0
`define SPARE_LANE_RESET        8'h00
`define READ_IDLE_VALUE         8'h00

`endif

// File: rtl/spare_lane_gate.v
/*
  Per-link lane gating: holds the applied spare-lane setting of one link and
  turns it, the mode's own lane needs and the link power-down into registered
  lane clock and serializer clock enables.
  Assumes the setting only changes while the transmitter is stopped.
*/
`timescale 1ns/1ns

module spare_lane_gate #(
  parameter LANES = 8
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             load_i,
  input  wire [LANES-1:1] spare_lane_i,
  input  wire             spare_ser_on_i,
  input  wire [LANES-1:0] mode_lanes_i,
  input  wire             power_down_i,
  output reg  [LANES-1:0] lane_clk_o,
  output reg  [LANES-1:0] ser_clk_o
);

  reg  [LANES-1:1] applied_lane;
  reg              applied_ser_on;
  wire [LANES-1:0] lane_req;
  wire [LANES-1:0] ser_req;
  wire [LANES-1:0] lower_all_on;

  // Setting is latched only while the link is stopped so lanes never change mid-frame
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      applied_lane   <= {(LANES-1){1'b0}};
      applied_ser_on <= 1'b0;
    end else if (load_i) begin
      applied_lane   <= spare_lane_i;
      applied_ser_on <= spare_ser_on_i;
    end
  end

  // Lane 0 has no spare bit; only the mode and the power-down decide it
  assign lane_req[0]     = mode_lanes_i[0] & ~power_down_i;
  assign ser_req[0]      = mode_lanes_i[0] & ~power_down_i;
  assign lower_all_on[0] = 1'b1;

  genvar n;
  generate
    for (n = 1; n < LANES; n = n + 1) begin : g_lane
      // Rate and format stay with the mode; only the enables are touched here
      assign lane_req[n]     = (mode_lanes_i[n] | applied_lane[n]) & ~power_down_i;
      assign ser_req[n]      = (mode_lanes_i[n] | (applied_lane[n] & applied_ser_on)) & ~power_down_i;
      assign lower_all_on[n] = lower_all_on[n-1] & lane_req[n-1];
    end
  endgenerate

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lane_clk_o <= {LANES{1'b0}};
      ser_clk_o  <= {LANES{1'b0}};
    end else begin
      lane_clk_o <= lane_req;
      ser_clk_o  <= ser_req & lower_all_on;
    end
  end

endmodule

// File: rtl/spare_lane_ctrl.v
/*
  Spare-lane enable register bank for two serial transmit links (A and B).
  Software writes one register per link: bits 7..1 force lane clocks of
  lanes 1..7, bit 0 also powers their serializers where every lower lane
  has its lane clock. Four status registers show the enables actually driven, one the pending writes.
  Assumes a simple register port (read data one cycle after the read
  strobe), mode lane needs and power-down supplied by neighbouring logic.
*/
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "spare_lane_map.vh"

module spare_lane_ctrl #(
  parameter LANES = `LANE_COUNT
) (
  input  wire                   CORE_CLK_I,
  input  wire                   SYS_RST_I,
  input  wire [`REG_ADDR_W-1:0] REG_ADDR_I,
  input  wire [`REG_DATA_W-1:0] REG_WDATA_I,
  input  wire                   REG_WRITE_I,
  input  wire                   REG_READ_I,
  output reg  [`REG_DATA_W-1:0] REG_RDATA_O,
  input  wire                   TRANSMITTER_GLOBAL_ENABLE_I,
  input  wire [1:0]             CHANNEL_POWER_DOWN_I,
  input  wire [LANES-1:0]       LINK_A_MODE_LANES_I,
  input  wire [LANES-1:0]       LINK_B_MODE_LANES_I,
  output wire [LANES-1:0]       LINK_A_LANE_CLK_O,
  output wire [LANES-1:0]       LINK_B_LANE_CLK_O,
  output wire [LANES-1:0]       LINK_A_SERIALIZER_CLK_O,
  output wire [LANES-1:0]       LINK_B_SERIALIZER_CLK_O
);

  localparam LINKS = 2;

  reg  [`REG_DATA_W-1:0] link_a_spare_lane_enable;
  reg  [`REG_DATA_W-1:0] link_b_spare_lane_enable;
  reg  [LINKS-1:0]       pending;
  reg  [`REG_DATA_W-1:0] next_rdata;
  wire [LINKS-1:0]       link_write;
  wire                   tx_stopped;
  wire [LANES-1:0]       lane_clk [0:LINKS-1];
  wire [LANES-1:0]       ser_clk  [0:LINKS-1];
  wire [LANES-1:0]       mode_lanes [0:LINKS-1];
  wire [`REG_DATA_W-1:0] spare_cfg  [0:LINKS-1];

  // Address decode shared by the write and the read paths
  function addr_hit;
    input [`REG_ADDR_W-1:0] addr;
    input [`REG_ADDR_W-1:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  assign tx_stopped    = ~TRANSMITTER_GLOBAL_ENABLE_I;
  assign link_write[0] = REG_WRITE_I & addr_hit(REG_ADDR_I, `LINK_A_SPARE_LANE_ADDR);
  assign link_write[1] = REG_WRITE_I & addr_hit(REG_ADDR_I, `LINK_B_SPARE_LANE_ADDR);

  assign mode_lanes[0] = LINK_A_MODE_LANES_I;
  assign mode_lanes[1] = LINK_B_MODE_LANES_I;
  assign spare_cfg[0]  = link_a_spare_lane_enable;
  assign spare_cfg[1]  = link_b_spare_lane_enable;

  // Software copies; all eight bits read back as written
  always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      link_a_spare_lane_enable <= `SPARE_LANE_RESET;
      link_b_spare_lane_enable <= `SPARE_LANE_RESET;
    end else begin
      if (link_write[0]) begin
        link_a_spare_lane_enable <= REG_WDATA_I;
      end
      if (link_write[1]) begin
        link_b_spare_lane_enable <= REG_WDATA_I;
      end
    end
  end

  // A write made while the link runs is held back, not dropped: it takes
  // effect once the transmitter stops. Set and clear never coincide since
  // one needs the transmitter running and the other needs it stopped.
  genvar k;
  generate
    for (k = 0; k < LINKS; k = k + 1) begin : g_pend
      always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
          pending[k] <= 1'b0;
        end else if (link_write[k] & ~tx_stopped) begin
          pending[k] <= 1'b1;
        end else if (tx_stopped) begin
          pending[k] <= 1'b0;
        end
      end
    end
  endgenerate

  generate
    for (k = 0; k < LINKS; k = k + 1) begin : g_link
      spare_lane_gate #(
        .LANES          (LANES)
      ) u_gate (
        .clk_i          (CORE_CLK_I),
        .rst_i          (SYS_RST_I),
        .load_i         (tx_stopped),
        .spare_lane_i   (spare_cfg[k][`SPARE_LANE_FIELD_MSB:`SPARE_LANE_FIELD_LSB]),
        .spare_ser_on_i (spare_cfg[k][`SPARE_SER_BIT]),
        .mode_lanes_i   (mode_lanes[k]),
        .power_down_i   (CHANNEL_POWER_DOWN_I[k]),
        .lane_clk_o     (lane_clk[k]),
        .ser_clk_o      (ser_clk[k])
      );
    end
  endgenerate

  // Outputs come straight from the gate flip-flops
  assign LINK_A_LANE_CLK_O       = lane_clk[0];
  assign LINK_B_LANE_CLK_O       = lane_clk[1];
  assign LINK_A_SERIALIZER_CLK_O = ser_clk[0];
  assign LINK_B_SERIALIZER_CLK_O = ser_clk[1];

  // Unmapped addresses read as zero; idle cycles also read as zero
  always @* begin
    next_rdata = `READ_IDLE_VALUE;
    if (REG_READ_I) begin
      if (addr_hit(REG_ADDR_I, `LINK_A_SPARE_LANE_ADDR)) begin
        next_rdata = link_a_spare_lane_enable;
      end else if (addr_hit(REG_ADDR_I, `LINK_B_SPARE_LANE_ADDR)) begin
        next_rdata = link_b_spare_lane_enable;
      end else if (addr_hit(REG_ADDR_I, `LINK_A_SER_STATUS_ADDR)) begin
        next_rdata = ser_clk[0];
      end else if (addr_hit(REG_ADDR_I, `LINK_B_SER_STATUS_ADDR)) begin
        next_rdata = ser_clk[1];
      end else if (addr_hit(REG_ADDR_I, `LINK_A_CLK_STATUS_ADDR)) begin
        next_rdata = lane_clk[0];
      end else if (addr_hit(REG_ADDR_I, `LINK_B_CLK_STATUS_ADDR)) begin
        next_rdata = lane_clk[1];
      end else if (addr_hit(REG_ADDR_I, `PENDING_STATUS_ADDR)) begin
        next_rdata = {{(`REG_DATA_W-LINKS){1'b0}}, pending};
      end
    end
  end

  always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= `READ_IDLE_VALUE;
    end else begin
      REG_RDATA_O <= next_rdata;
    end
  end

endmodule

// File: testbench/spare_lane_checker.sv
/* Assertions on the spare-lane outputs and the read port.
   Sees only the top module's ports; bound below. */
`timescale 1ns/1ns
module spare_lane_checker #(
  parameter LANES = 8
) (
  input wire logic             CORE_CLK_I,
  input wire logic             SYS_RST_I,
  input wire logic [11:0]      REG_ADDR_I,
  input wire logic             REG_READ_I,
  input wire logic [7:0]       REG_RDATA_O,
  input wire logic [1:0]       CHANNEL_POWER_DOWN_I,
  input wire logic [LANES-1:0] LINK_A_MODE_LANES_I,
  input wire logic [LANES-1:0] LINK_A_LANE_CLK_O,
  input wire logic [LANES-1:0] LINK_B_LANE_CLK_O,
  input wire logic [LANES-1:0] LINK_A_SERIALIZER_CLK_O,
  input wire logic [LANES-1:0] LINK_B_SERIALIZER_CLK_O
);
  // A serializer may run only if every lower lane has its lane clock
  function automatic logic chain_ok(input logic [LANES-1:0] l, input logic [LANES-1:0] s);
    chain_ok = 1'b1;
    for (int n = 1; n < LANES; n++)
      if (s[n] && (l & ((1 << n) - 1)) != ((1 << n) - 1))
        chain_ok = 1'b0;
  endfunction
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  chk_pd_a_off: assert property (CHANNEL_POWER_DOWN_I[0] |=>
    LINK_A_LANE_CLK_O == 0 && LINK_A_SERIALIZER_CLK_O == 0) else $error("link A active while down");
  chk_pd_b_off: assert property (CHANNEL_POWER_DOWN_I[1] |=>
    LINK_B_LANE_CLK_O == 0 && LINK_B_SERIALIZER_CLK_O == 0) else $error("link B active while down");
  chk_mode_lanes_a: assert property (!CHANNEL_POWER_DOWN_I[0] |=>
    (LINK_A_LANE_CLK_O & $past(LINK_A_MODE_LANES_I)) == $past(LINK_A_MODE_LANES_I))
    else $error("mode lane of link A not clocked");
  chk_lane_zero_a: assert property (1'b1 |=>
    LINK_A_LANE_CLK_O[0] == $past(LINK_A_MODE_LANES_I[0] & !CHANNEL_POWER_DOWN_I[0]))
    else $error("lane 0 of link A wrong");
  chk_ser_in_lane: assert property (((LINK_A_SERIALIZER_CLK_O & ~LINK_A_LANE_CLK_O) |
    (LINK_B_SERIALIZER_CLK_O & ~LINK_B_LANE_CLK_O)) == 0) else $error("serializer without lane clock");
  chk_ser_chain: assert property (chain_ok(LINK_A_LANE_CLK_O, LINK_A_SERIALIZER_CLK_O) &&
    chain_ok(LINK_B_LANE_CLK_O, LINK_B_SERIALIZER_CLK_O)) else $error("serializer above a gap");
  chk_lane_status_a: assert property (REG_READ_I && REG_ADDR_I == 12'h2b2 |=>
    REG_RDATA_O == $past(LINK_A_LANE_CLK_O)) else $error("lane status of link A wrong");
  chk_ser_status_b: assert property (REG_READ_I && REG_ADDR_I == 12'h2b1 |=>
    REG_RDATA_O == $past(LINK_B_SERIALIZER_CLK_O)) else $error("serializer status of link B wrong");
endmodule
bind spare_lane_ctrl spare_lane_checker #(.LANES(LANES)) spare_lane_checker_inst (.*);

// File: testbench/testbench.sv
/* Self-checking bench of spare_lane_ctrl.
   Drives the register port, mode lanes, power-down and transmitter enable. */
`timescale 1ns/1ns
`include "spare_lane_map.vh"
module testbench;
  reg         clk, rst, we, re, tx;
  reg  [11:0] addr;
  reg  [7:0]  wd, ma, mb;
  reg  [1:0]  pd;
  wire [7:0]  rdata, la, lb, sa, sb;
  int         error_cnt, n_tests;
  // Written value, expected lane clocks, expected serializers; mode is lane 0
  logic [7:0] tab [0:4][0:2] = '{'{8'h06, 8'h07, 8'h01}, '{8'h07, 8'h07, 8'h07},
    '{8'h09, 8'h09, 8'h01}, '{8'hfe, 8'hff, 8'h01}, '{8'hff, 8'hff, 8'hff}};
  spare_lane_ctrl spare_lane_ctrl_inst (.CORE_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_WRITE_I(we), .REG_READ_I(re), .REG_RDATA_O(rdata),
    .TRANSMITTER_GLOBAL_ENABLE_I(tx), .CHANNEL_POWER_DOWN_I(pd), .LINK_A_MODE_LANES_I(ma),
    .LINK_B_MODE_LANES_I(mb), .LINK_A_LANE_CLK_O(la), .LINK_B_LANE_CLK_O(lb),
    .LINK_A_SERIALIZER_CLK_O(sa), .LINK_B_SERIALIZER_CLK_O(sb));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    we   <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask
  // Write to outputs takes two edges; one spare edge for margin
  task settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task outs(input logic l, input logic [7:0] el, input logic [7:0] es);
    check(l ? lb : la, el);
    check(l ? sb : sa, es);
  endtask
  task complete_run;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run;
  end
  initial begin
    {rst, we, re, tx, addr, wd, ma, mb, pd} = {4'h8, 12'h000, 8'h00, 8'h00, 8'h00, 2'b00};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Mode lanes stay off until the reset values have been looked at
    rd(`LINK_A_SPARE_LANE_ADDR, 8'h00);
    rd(`LINK_B_SPARE_LANE_ADDR, 8'h00);
    check(la | lb | sa | sb, 8'h00);
    @(posedge clk);
    ma  <= 8'h01;
    mb  <= 8'h01;
    for (int l = 0; l < 2; l++)
      for (int i = 0; i < 5; i++) begin
        wr(`LINK_A_SPARE_LANE_ADDR + 12'(l), tab[i][0]);
        settle;
        outs(l[0], tab[i][1], tab[i][2]);
      end
    @(posedge clk);
    ma <= 8'h10;
    wr(`LINK_A_SPARE_LANE_ADDR, 8'h00);
    settle;
    outs(1'b0, 8'h10, 8'h00);
    @(posedge clk);
    ma <= 8'h01;
    wr(`LINK_A_SPARE_LANE_ADDR, 8'hff);
    pd <= 2'b01;
    settle;
    outs(1'b0, 8'h00, 8'h00);
    outs(1'b1, 8'hff, 8'hff);
    @(posedge clk);
    pd <= 2'b10;
    settle;
    outs(1'b1, 8'h00, 8'h00);
    outs(1'b0, 8'hff, 8'hff);
    @(posedge clk);
    pd <= 2'b00;
    settle;
    rd(`LINK_A_CLK_STATUS_ADDR, 8'hff);
    rd(`LINK_B_SER_STATUS_ADDR, 8'hff);
    rd(12'h20c, 8'h00);
    wr(`LINK_A_SER_STATUS_ADDR, 8'h00);
    rd(`LINK_A_SER_STATUS_ADDR, 8'hff);
    @(posedge clk);
    tx <= 1'b1;
    wr(`LINK_A_SPARE_LANE_ADDR, 8'h06);
    rd(`LINK_A_SPARE_LANE_ADDR, 8'h06);
    rd(`PENDING_STATUS_ADDR, 8'h01);
    outs(1'b0, 8'hff, 8'hff);
    @(posedge clk);
    tx <= 1'b0;
    settle;
    outs(1'b0, 8'h07, 8'h01);
    rd(`PENDING_STATUS_ADDR, 8'h00);
    complete_run;
  end
endmodule
